// ### gsn_pkg.sv
/*
 * Shared constants and types for the pin state and notification block:
 * register offsets, reset values, packet field values and the sender states.
 * Assumes a register port whose addresses are the printed register offsets.
 */
package gsn_pkg;

    // Port widths
    localparam int NPINS  = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] OFF_PIN_OUTPUT_CLEAR = 8'h0F;
    localparam logic [7:0] OFF_PIN_LEVEL        = 8'h10;
    localparam logic [7:0] OFF_PIN_CHANGE_MASK  = 8'h11;
    localparam logic [7:0] OFF_NOTIF_FORMAT     = 8'h12;

    // Values after reset
    localparam logic [9:0] OUT_RST  = 10'h000;
    localparam logic [9:0] MASK_RST = 10'h100;
    localparam logic [1:0] FMT_RST  = 2'h0;

    // Field positions in the notification-format register
    localparam int FMT_VENDOR_BIT = 0;
    localparam int FMT_BREAK_BIT  = 1;

    // Standard packet fields
    localparam logic [7:0]  STD_REQ_TYPE = 8'hA1;
    localparam logic [7:0]  STD_NOTIF    = 8'h20;
    localparam logic [15:0] STD_VALUE    = 16'h0000;
    localparam logic [7:0]  STD_IFACE    = 8'h00;
    localparam logic [15:0] STD_LENGTH   = 16'h0002;

    // Index of the first byte, and of the last byte of each layout
    localparam logic [3:0] STD_LAST_IDX = 4'h9;
    localparam logic [3:0] VND_LAST_IDX = 4'h4;
    localparam logic [3:0] IDX_FIRST    = 4'h0;

    // Packet sender states, Gray coded along idle, load, send
    typedef enum logic [1:0] {
        GSN_IDLE = 2'b00,
        GSN_LOAD = 2'b01,
        GSN_SEND = 2'b11
    } gsn_state_t;

endpackage

// ### gsn_pkt_if.sv
/*
 * Carrier between the register core and the packet byte formatter.
 * Assumes the core holds the snapshot stable while a packet is sent.
 */
`timescale 1ns/1ns
interface gsn_pkt_if;
    logic [9:0] lvl;
    logic [9:0] chg;
    logic       ovr;
    logic       par;
    logic       frm;
    logic       ring;
    logic       brk;
    logic       dsr;
    logic       cd;
    logic       vendor;
    logic [3:0] idx;
    logic [7:0] pkt_byte;

    modport core (output lvl, chg, ovr, par, frm, ring, brk, dsr, cd, vendor, idx,
                  input pkt_byte);
    modport fmt  (input lvl, chg, ovr, par, frm, ring, brk, dsr, cd, vendor, idx,
                  output pkt_byte);
endinterface

// ### gsn_pkt_fmt.sv
/*
 * Packet byte formatter: returns the byte at a given index of the standard
 * or the vendor notification layout. Purely combinational.
 * Assumes the core registers the byte before it leaves the block.
 */
`timescale 1ns/1ns
module gsn_pkt_fmt
    import gsn_pkg::*;
(
    gsn_pkt_if.fmt p
);

    ////////////////////////////////////////////////////////////////////////////
    // Standard layout, ten bytes, words little endian
    function automatic logic [7:0] std_byte(input logic [3:0] i);
        unique case (i)
            4'h0:    std_byte = STD_REQ_TYPE;
            4'h1:    std_byte = STD_NOTIF;
            4'h2:    std_byte = STD_VALUE[7:0];
            4'h3:    std_byte = STD_VALUE[15:8];
            4'h4:    std_byte = STD_IFACE;
            4'h5:    std_byte = 8'h00;
            4'h6:    std_byte = STD_LENGTH[7:0];
            4'h7:    std_byte = STD_LENGTH[15:8];
            4'h8:    std_byte = {1'b0, p.ovr, p.par, p.frm,
                                 p.ring, p.brk, p.dsr, p.cd};
            default: std_byte = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Vendor layout, five bytes
    function automatic logic [7:0] vnd_byte(input logic [3:0] i);
        unique case (i)
            4'h0:    vnd_byte = p.lvl[7:0];
            4'h1:    vnd_byte = {6'h00, p.lvl[9:8]};
            4'h2:    vnd_byte = p.chg[7:0];
            4'h3:    vnd_byte = {6'h00, p.chg[9:8]};
            default: vnd_byte = {4'h0, p.ovr, p.par, p.frm, p.brk};
        endcase
    endfunction

    // Layout chosen by the snapshot of the format bit
    always_comb begin
        p.pkt_byte = p.vendor ? vnd_byte(p.idx) : std_byte(p.idx);
    end

endmodule

// ### gsn_core.sv
/*
 * Pin output clear and level registers, pin change masking and the
 * notification packet sender of one serial channel.
 * Assumes the register port and the UART status inputs are on sys_clk,
 * pin levels arrive asynchronously, and the host side drains the packet
 * byte stream with a valid and ready handshake.
 */
`timescale 1ns/1ns

// Behaviour
// - Clear-register one bits drive matching general-purpose outputs low.
// - Clear-register zero bits leave outputs unchanged.
// - Clear register ignores pins given to an alternate function.
// - Clear register ignores general-purpose pins set as inputs.
// - Level register reads present level of all ten pins.
// - Level register write sets each general-purpose output to the written bit.
// - Unmasked input change raises a packet; mask resets to 0x100.
// - Change masking applies to every input, general purpose or alternate.
// - Masked pins still read; vendor packets carry current pin levels, standard packets carry none.
// - Format bit 1 enables break characters as a packet trigger.
// - Format bit 0 picks standard or vendor layout; both reset to zero.
// - Standard packet: 0xA1, 0x20, zero value, length 0x0002.
// - Standard index word: zero high byte, interface 0x00 low byte.
// - Overrun flag means received characters were discarded inside the device.
// - Vendor packet bytes 0-3: pin levels then change flags.
// - Direction bit zero is input, one is output; only outputs take writes.
module gsn_core
    import gsn_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [NPINS-1:0]  gpio_alt_sel,
    input  wire logic [NPINS-1:0]  gpio_dir,
    input  wire logic [NPINS-1:0]  pin_in,
    output logic      [NPINS-1:0]  gpio_out,
    output logic      [NPINS-1:0]  gpio_oe,
    input  wire logic              uart_break,
    input  wire logic              uart_overrun,
    input  wire logic              uart_parity_err,
    input  wire logic              uart_framing_err,
    input  wire logic              modem_ring,
    input  wire logic              modem_dsr,
    input  wire logic              modem_cd,
    output logic                   pkt_valid,
    output logic      [7:0]        pkt_data,
    output logic                   pkt_last,
    input  wire logic              pkt_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Register address decode, shared by read and write paths
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic             wr_clear;
    logic             wr_level;
    logic             wr_mask;
    logic             wr_fmt;
    logic [NPINS-1:0] gp_out_pins;
    logic [NPINS-1:0] in_pins;

    // Write strobes per register
    assign wr_clear = reg_wr & hit(reg_addr, OFF_PIN_OUTPUT_CLEAR);
    assign wr_level = reg_wr & hit(reg_addr, OFF_PIN_LEVEL);
    assign wr_mask  = reg_wr & hit(reg_addr, OFF_PIN_CHANGE_MASK);
    assign wr_fmt   = reg_wr & hit(reg_addr, OFF_NOTIF_FORMAT);

    // Pins owned by the output writes: general purpose and set as output
    assign gp_out_pins = gpio_dir & ~gpio_alt_sel;
    // Pins not driven as general-purpose outputs count as inputs
    assign in_pins     = ~gp_out_pins;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; stage one feeds only stage two
    logic [NPINS-1:0] sync1_ff;
    logic [NPINS-1:0] sync2_ff;
    logic [NPINS-1:0] prev_ff;
    logic [NPINS-1:0] nxt_sync1;
    logic [NPINS-1:0] nxt_sync2;
    logic [NPINS-1:0] nxt_prev;
    logic [NPINS-1:0] pin_edge;

    always_comb begin
        nxt_sync1 = pin_in;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    // A level change seen after synchronisation
    assign pin_edge = sync2_ff ^ prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Control registers: output levels, change mask, format select
    logic [NPINS-1:0] out_ff;
    logic [NPINS-1:0] mask_ff;
    logic [1:0]       fmt_ff;
    logic [NPINS-1:0] nxt_out;
    logic [NPINS-1:0] nxt_mask;
    logic [1:0]       nxt_fmt;

    always_comb begin
        nxt_out  = out_ff;
        nxt_mask = mask_ff;
        nxt_fmt  = fmt_ff;
        if (wr_clear) begin
            // Only selected general-purpose outputs drop low
            nxt_out = out_ff & ~(reg_wdata[NPINS-1:0] & gp_out_pins);
        end
        if (wr_level) begin
            // Written bit value lands on general-purpose outputs only
            nxt_out = (out_ff & ~gp_out_pins)
                    | (reg_wdata[NPINS-1:0] & gp_out_pins);
        end
        if (wr_mask) begin
            // Upper bits dropped; software keeps them zero anyway
            nxt_mask = reg_wdata[NPINS-1:0];
        end
        if (wr_fmt) begin
            nxt_fmt = reg_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_ff  <= OUT_RST;
            mask_ff <= MASK_RST;
            fmt_ff  <= FMT_RST;
        end else begin
            out_ff  <= nxt_out;
            mask_ff <= nxt_mask;
            fmt_ff  <= nxt_fmt;
        end
    end

    // Pad drive; alternate-function drive lives outside this block
    assign gpio_out = out_ff;
    assign gpio_oe  = gp_out_pins;

    ////////////////////////////////////////////////////////////////////////////
    // Register read data, one cycle after the read strobe
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            nxt_rdata = '0;                    // Clear register and holes read zero
            if (hit(reg_addr, OFF_PIN_LEVEL)) begin
                nxt_rdata[NPINS-1:0] = sync2_ff;
            end
            if (hit(reg_addr, OFF_PIN_CHANGE_MASK)) begin
                nxt_rdata[NPINS-1:0] = mask_ff;
            end
            if (hit(reg_addr, OFF_NOTIF_FORMAT)) begin
                nxt_rdata[1:0] = fmt_ff;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event flags; a new event always wins over the clear
    logic [NPINS-1:0] chg_ff;
    logic             brk_ff;
    logic             brk_lvl_ff;
    logic             ovr_ff;
    logic             par_ff;
    logic             frm_ff;
    logic [NPINS-1:0] nxt_chg;
    logic             nxt_brk;
    logic             nxt_brk_lvl;
    logic             nxt_ovr;
    logic             nxt_par;
    logic             nxt_frm;
    logic [NPINS-1:0] chg_set;
    logic             brk_set;
    logic             pkt_done;
    logic             pending;

    // Snapshot of what the current packet reports
    gsn_pkt_if        pif();
    logic [NPINS-1:0] s_lvl_ff;
    logic [NPINS-1:0] s_chg_ff;
    logic             s_ovr_ff;
    logic             s_par_ff;
    logic             s_frm_ff;
    logic             s_brk_ff;
    logic             s_ring_ff;
    logic             s_dsr_ff;
    logic             s_cd_ff;
    logic             s_vnd_ff;

    // Unmasked input changes only; masked pins still read normally
    assign chg_set = pin_edge & ~mask_ff & in_pins;
    // Break counts as a trigger only while enabled
    assign brk_set = uart_break & ~brk_lvl_ff & fmt_ff[FMT_BREAK_BIT];

    always_comb begin
        nxt_brk_lvl = uart_break;
        nxt_chg     = chg_ff;
        nxt_brk     = brk_ff;
        nxt_ovr     = ovr_ff;
        nxt_par     = par_ff;
        nxt_frm     = frm_ff;
        if (pkt_done) begin
            // Drop only what the accepted packet carried
            nxt_chg = chg_ff & ~s_chg_ff;
            nxt_brk = brk_ff & ~s_brk_ff;
            nxt_ovr = ovr_ff & ~s_ovr_ff;
            nxt_par = par_ff & ~s_par_ff;
            nxt_frm = frm_ff & ~s_frm_ff;
        end
        nxt_chg = nxt_chg | chg_set;
        nxt_brk = nxt_brk | brk_set;
        nxt_ovr = nxt_ovr | uart_overrun;
        nxt_par = nxt_par | uart_parity_err;
        nxt_frm = nxt_frm | uart_framing_err;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chg_ff     <= '0;
            brk_ff     <= 1'b0;
            brk_lvl_ff <= 1'b0;
            ovr_ff     <= 1'b0;
            par_ff     <= 1'b0;
            frm_ff     <= 1'b0;
        end else begin
            chg_ff     <= nxt_chg;
            brk_ff     <= nxt_brk;
            brk_lvl_ff <= nxt_brk_lvl;
            ovr_ff     <= nxt_ovr;
            par_ff     <= nxt_par;
            frm_ff     <= nxt_frm;
        end
    end

    // Any latched trigger queues one packet
    assign pending = (|chg_ff) | brk_ff | ovr_ff | par_ff | frm_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Packet sender: snapshot, load first byte, stream bytes
    gsn_state_t state_ff;
    gsn_state_t nxt_state;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [7:0] data_ff;
    logic [7:0] nxt_data;
    logic       take_snap;
    logic       is_last;

    assign is_last  = (idx_ff == (s_vnd_ff ? VND_LAST_IDX : STD_LAST_IDX));
    assign pkt_done = (state_ff == GSN_SEND) & pkt_ready & is_last;

    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        nxt_data  = data_ff;
        take_snap = 1'b0;
        unique case (state_ff)
            GSN_IDLE: begin
                if (pending) begin
                    take_snap = 1'b1;
                    nxt_idx   = IDX_FIRST;
                    nxt_state = GSN_LOAD;
                end
            end
            GSN_LOAD: begin
                nxt_data  = pif.pkt_byte;
                nxt_state = GSN_SEND;
            end
            GSN_SEND: begin
                if (pkt_ready) begin
                    if (is_last) begin
                        nxt_state = GSN_IDLE;
                    end else begin
                        nxt_idx   = idx_ff + 4'h1;
                        nxt_state = GSN_LOAD;
                    end
                end
            end
            default: nxt_state = GSN_IDLE;     // Recover from an illegal code
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= GSN_IDLE;
            idx_ff   <= IDX_FIRST;
            data_ff  <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            data_ff  <= nxt_data;
        end
    end

    // Snapshot is frozen for the packet; only the break bit also follows the live level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_lvl_ff  <= '0;
            s_chg_ff  <= '0;
            s_ovr_ff  <= 1'b0;
            s_par_ff  <= 1'b0;
            s_frm_ff  <= 1'b0;
            s_brk_ff  <= 1'b0;
            s_ring_ff <= 1'b0;
            s_dsr_ff  <= 1'b0;
            s_cd_ff   <= 1'b0;
            s_vnd_ff  <= 1'b0;
        end else if (take_snap) begin
            s_lvl_ff  <= sync2_ff;
            s_chg_ff  <= chg_ff;
            s_ovr_ff  <= ovr_ff;
            s_par_ff  <= par_ff;
            s_frm_ff  <= frm_ff;
            s_brk_ff  <= brk_ff;
            s_ring_ff <= modem_ring;
            s_dsr_ff  <= modem_dsr;
            s_cd_ff   <= modem_cd;
            s_vnd_ff  <= fmt_ff[FMT_VENDOR_BIT];
        end
    end

    // Break status shows the latched event or the live level
    assign pif.lvl    = s_lvl_ff;
    assign pif.chg    = s_chg_ff;
    assign pif.ovr    = s_ovr_ff;
    assign pif.par    = s_par_ff;
    assign pif.frm    = s_frm_ff;
    assign pif.brk    = s_brk_ff | brk_lvl_ff;
    assign pif.ring   = s_ring_ff;
    assign pif.dsr    = s_dsr_ff;
    assign pif.cd     = s_cd_ff;
    assign pif.vendor = s_vnd_ff;
    assign pif.idx    = idx_ff;

    gsn_pkt_fmt u_fmt (
        .p (pif.fmt)
    );

    // Handshake outputs
    assign pkt_valid = (state_ff == GSN_SEND);
    assign pkt_last  = (state_ff == GSN_SEND) & is_last;
    assign pkt_data  = data_ff;

endmodule

// ### gsn_core_sva.sv
/*
 * Port checker for the pin state and notification core.
 * Assumes a single sys_clk domain with synchronous active-high srst.
 */
`timescale 1ns/1ns
module gsn_core_sva
    import gsn_pkg::*;
(
    wire logic              sys_clk,
    wire logic              srst,
    wire logic              reg_wr,
    wire logic              reg_rd,
    wire logic [ADDR_W-1:0] reg_addr,
    wire logic [DATA_W-1:0] reg_wdata,
    wire logic [DATA_W-1:0] reg_rdata,
    wire logic [NPINS-1:0]  gpio_alt_sel,
    wire logic [NPINS-1:0]  gpio_dir,
    wire logic [NPINS-1:0]  gpio_out,
    wire logic [NPINS-1:0]  gpio_oe,
    wire logic              pkt_valid,
    wire logic [7:0]        pkt_data,
    wire logic              pkt_last,
    wire logic              pkt_ready
);
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [9:0] wbits;

    // Byte position inside the packet, so the length can be judged
    assign wbits = reg_wdata[9:0];
    always_comb begin
        nxt_idx = idx_ff;
        if (pkt_valid && pkt_ready)
            nxt_idx = pkt_last ? 4'h0 : idx_ff + 4'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (srst)
            idx_ff <= 4'h0;
        else
            idx_ff <= nxt_idx;
    end

    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Mid-packet handshake, then one idle cycle before the next byte
    sequence s_accept_mid;
        pkt_valid && pkt_ready && !pkt_last;
    endsequence
    sequence s_gap_offer;
        !pkt_valid ##1 pkt_valid;
    endsequence

    a_byte_gap: assert property (s_accept_mid |=> s_gap_offer)
        else $error("next packet byte not offered after one idle cycle");
    a_byte_hold: assert property (pkt_valid && !pkt_ready |=>
        pkt_valid && $stable(pkt_data) && $stable(pkt_last))
        else $error("offered packet byte changed before acceptance");
    a_pkt_length: assert property (pkt_valid && pkt_last |->
        idx_ff == 4'h4 || idx_ff == 4'h9)
        else $error("packet length is neither five nor ten bytes");
    a_drive_enable: assert property (gpio_oe == (gpio_dir & ~gpio_alt_sel))
        else $error("output enable does not follow direction and function");
    a_clear_out: assert property (reg_wr && reg_addr == OFF_PIN_OUTPUT_CLEAR |=>
        gpio_out == ($past(gpio_out) & ~($past(wbits) & $past(gpio_oe))))
        else $error("clear write gave a wrong output level");
    a_level_out: assert property (reg_wr && reg_addr == OFF_PIN_LEVEL |=>
        gpio_out == (($past(gpio_out) & ~$past(gpio_oe)) | ($past(wbits) & $past(gpio_oe))))
        else $error("level write gave a wrong output level");
    a_out_quiet: assert property (!reg_wr |=> $stable(gpio_out))
        else $error("output level moved without a write");
    a_clear_reads0: assert property (reg_rd && reg_addr == OFF_PIN_OUTPUT_CLEAR |=>
        reg_rdata == 16'h0000)
        else $error("write-only clear register read non-zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

bind gsn_core gsn_core_sva gsn_core_sva_i (
    .sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .gpio_alt_sel(gpio_alt_sel), .gpio_dir(gpio_dir), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready));

// ### gsn_host_model.sv
/*
 * Host side of the notification stream: drains packet bytes into a queue.
 * Assumes valid/ready on sys_clk; slow makes it accept every other cycle.
 */
`timescale 1ns/1ns
module gsn_host_model (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       pkt_valid,
    input  wire logic [7:0] pkt_data,
    input  wire logic       pkt_last,
    input  wire logic       slow,
    output logic            pkt_ready
);
    logic [8:0] rx_q[$];
    logic       nxt_ready;

    ////////////////////////////////////////
    // Stalling host toggles ready, so only the first byte of a packet can wait while offered
    always_comb begin
        nxt_ready = slow ? ~pkt_ready : 1'b1;
    end
    always_ff @(posedge sys_clk) begin
        pkt_ready <= srst ? 1'b0 : nxt_ready;
    end

    // Keep the end marker with each byte for the bench to compare
    always @(posedge sys_clk) begin
        if (!srst && pkt_valid && pkt_ready)
            rx_q.push_back({pkt_last, pkt_data});
    end
endmodule

// ### tb_top.sv
/*
 * Self-checking bench for the pin state and notification core.
 * Assumes the bound checker and the host model beside the design.
 */
`timescale 1ns/1ns
module tb_top
    import gsn_pkg::*;
;
    logic              sys_clk, srst, reg_wr, reg_rd, slow, pkt_valid, pkt_last, pkt_ready;
    logic              uart_break, uart_overrun, uart_parity_err, uart_framing_err;
    logic              modem_ring, modem_dsr, modem_cd, clr;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, d;
    logic [NPINS-1:0]  gpio_alt_sel, gpio_dir, pin_in, gpio_out, gpio_oe, exp_out, oe, lv;
    logic [7:0]        pkt_data;
    logic [31:0]       seed;
    int                miscompares, n_tests, base;

    gsn_core gsn_core_i (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .gpio_alt_sel(gpio_alt_sel), .gpio_dir(gpio_dir), .pin_in(pin_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .uart_break(uart_break),
        .uart_overrun(uart_overrun), .uart_parity_err(uart_parity_err),
        .uart_framing_err(uart_framing_err), .modem_ring(modem_ring), .modem_dsr(modem_dsr),
        .modem_cd(modem_cd), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_ready(pkt_ready));
    gsn_host_model gsn_host_model_i (.sys_clk(sys_clk), .srst(srst), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .pkt_last(pkt_last), .slow(slow), .pkt_ready(pkt_ready));

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected {end marker, byte} at position i of either layout
    function automatic logic [8:0] exp_byte(input logic vnd, input int i,
        input logic [9:0] lvl, input logic [9:0] ch, input logic [7:0] st);
        logic [7:0] b;
        if (vnd)
            b = i == 0 ? lvl[7:0] : i == 1 ? {6'h00, lvl[9:8]} : i == 2 ? ch[7:0] :
                i == 3 ? {6'h00, ch[9:8]} : st;
        else
            b = i == 0 ? 8'hA1 : i == 1 ? 8'h20 : i == 6 ? 8'h02 : i == 8 ? st : 8'h00;
        return {i == (vnd ? 4 : 9), b};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rd_val = reg_rdata;
    endtask
    // Bounded wait for a whole packet, then byte by byte compare
    task automatic expect_pkt(input logic vnd, input logic [9:0] lvl, input logic [9:0] ch,
        input logic [7:0] st);
        int n;
        n = vnd ? 5 : 10;
        for (int t = 0; t < 400 && gsn_host_model_i.rx_q.size() < base + n; t++)
            @(posedge sys_clk);
        chk("packet count", 16'(base + n), 16'(gsn_host_model_i.rx_q.size()));
        for (int i = 0; i < n; i++)
            chk("packet byte", {7'h00, exp_byte(vnd, i, lvl, ch, st)},
                {7'h00, gsn_host_model_i.rx_q[base + i]});
        base += n;
    endtask
    task automatic no_pkt();
        repeat (30) @(posedge sys_clk);
        chk("packet count", 16'(base), 16'(gsn_host_model_i.rx_q.size()));
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        $display("Error watchdog expected done seen hang");
        give_verdict();
    end

    initial begin
        {srst, reg_wr, reg_rd, slow, uart_break, uart_overrun, uart_parity_err} = 7'h40;
        {uart_framing_err, modem_ring, modem_dsr, modem_cd} = 4'h0;
        {reg_addr, reg_wdata, gpio_alt_sel, gpio_dir, pin_in} = '0;
        {miscompares, n_tests, base} = '0;
        seed = 32'h0472037D;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(OFF_PIN_CHANGE_MASK);
        chk("mask reset", 16'h0100, rd_val);
        rd(OFF_NOTIF_FORMAT);
        chk("format reset", 16'h0000, rd_val);
        rd(OFF_PIN_OUTPUT_CLEAR);
        chk("clear read", 16'h0000, rd_val);
        rd(8'h3C);
        chk("unmapped read", 16'h0000, rd_val);
        $display("Test reset values done");
        // Corner writes first, then random direction, function and data
        exp_out = 10'h000;
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            oe = k < 3 ? 10'h3FF : seed[9:0] & ~seed[19:10];
            gpio_dir <= k < 3 ? 10'h3FF : seed[9:0];
            gpio_alt_sel <= k < 3 ? 10'h000 : seed[19:10];
            d = k == 0 ? 16'h03FF : k == 1 ? 16'h0000 : k == 2 ? 16'h0201 : seed[31:16];
            clr = k == 1 || k == 2 || (k > 2 && k[0]);
            wr(clr ? OFF_PIN_OUTPUT_CLEAR : OFF_PIN_LEVEL, d);
            exp_out = clr ? exp_out & ~(d[9:0] & oe) : (exp_out & ~oe) | (d[9:0] & oe);
            @(posedge sys_clk);
            chk("output level", {6'h00, exp_out}, {6'h00, gpio_out});
            chk("output enable", {6'h00, oe}, {6'h00, gpio_oe});
        end
        $display("Test output levels done");
        gpio_dir <= 10'h000;
        wr(OFF_PIN_CHANGE_MASK, 16'h03FF);
        seed = lfsr(seed);
        pin_in <= seed[9:0];
        gpio_alt_sel <= seed[19:10];
        repeat (6) @(posedge sys_clk);
        rd(OFF_PIN_LEVEL);
        chk("pin level", {6'h00, seed[9:0]}, rd_val);
        no_pkt();
        $display("Test masked pins done");
        wr(OFF_PIN_CHANGE_MASK, 16'h03F7);
        {modem_ring, modem_dsr, modem_cd} <= 3'h7;
        gpio_alt_sel <= 10'h008;
        pin_in <= pin_in ^ 10'h028;
        expect_pkt(1'b0, 10'h000, 10'h000, 8'h0B);
        $display("Test standard packet done");
        wr(OFF_NOTIF_FORMAT, 16'h0001);
        slow <= 1'b1;
        lv = pin_in ^ 10'h028;
        pin_in <= lv;
        expect_pkt(1'b1, lv, 10'h008, 8'h00);
        {uart_overrun, uart_parity_err, uart_framing_err} <= 3'h7;
        @(posedge sys_clk);
        {uart_overrun, uart_parity_err, uart_framing_err} <= 3'h0;
        expect_pkt(1'b1, lv, 10'h000, 8'h0E);
        $display("Test vendor packets done");
        uart_break <= 1'b1;
        no_pkt();
        uart_break <= 1'b0;
        wr(OFF_NOTIF_FORMAT, 16'h0003);
        uart_break <= 1'b1;
        expect_pkt(1'b1, lv, 10'h000, 8'h01);
        uart_break <= 1'b0;
        $display("Test break trigger done");
        give_verdict();
    end
endmodule
